// File: rtl/ptc_pkg.sv
// constants shared by the paired timer counter block
// assumes one 125 MHz clock and 16-bit byte addresses on the register port
package ptc_pkg;

  localparam int CH_NUM   = 6;
  localparam int PAIR_NUM = 3;
  localparam int DATA_W   = 8;
  localparam int ADDR_W   = 16;
  localparam int SEL_W    = 2;

  // reset values and compare substitution
  localparam logic [7:0] CMP_RESET = 8'hff;
  localparam logic [7:0] CNT_RESET = 8'h00;
  localparam logic [7:0] CMP_ZERO  = 8'h00;
  localparam logic [7:0] CMP_SUBST = 8'h01;
  localparam logic [7:0] CNT_ONE   = 8'h01;

  // channel order: 0, 1, 8, 9, a, b; pairs are (0,1) (2,3) (4,5)
  localparam logic [15:0] CMP_ADDR [CH_NUM] = '{
    16'hf030, 16'hf034, 16'hf8e0, 16'hf8e4, 16'hf8e8, 16'hf8ec};
  localparam logic [15:0] CNT_ADDR [CH_NUM] = '{
    16'hf031, 16'hf035, 16'hf8e1, 16'hf8e5, 16'hf8e9, 16'hf8ed};

  // block control and status registers
  localparam logic [15:0] RUN_ADDR     = 16'hf040;
  localparam logic [15:0] MODE_ADDR    = 16'hf041;
  localparam logic [15:0] SEL_LO_ADDR  = 16'hf042;
  localparam logic [15:0] SEL_HI_ADDR  = 16'hf043;
  localparam logic [15:0] INT_ST_ADDR  = 16'hf044;
  localparam logic [15:0] INT_MSK_ADDR = 16'hf045;
  localparam logic [15:0] RD_OK_ADDR   = 16'hf046;

  // field positions
  localparam int SEL_LO_CH  = 4;
  localparam int SEL_HI_CH  = 2;
  localparam int SEL_LO_POS = 0;
  localparam int SEL_HI_POS = 8;

  // count clock selection codes
  localparam logic [1:0] SEL_LOW  = 2'h0;
  localparam logic [1:0] SEL_HTB  = 2'h1;
  localparam logic [1:0] SEL_OFF  = 2'h2;
  localparam logic [1:0] SEL_EXT  = 2'h3;

  localparam logic [5:0]  CH_RESET  = 6'h00;
  localparam logic [2:0]  MODE_RESET = 3'h0;
  localparam logic [11:0] SEL_RESET = 12'h000;

endpackage

// File: rtl/ptc_pair.sv
// one pair of 8-bit counters with compare registers, joinable to 16 bits
// assumes ticks are single-cycle pulses on clk and writes come one a cycle
`timescale 1ns/100ps
module ptc_pair
  import ptc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       tick_lo,
  input  wire logic       tick_hi,
  input  wire logic       mode16,
  input  wire logic       wr_cmp_lo,
  input  wire logic       wr_cmp_hi,
  input  wire logic       wr_cnt_lo,
  input  wire logic       wr_cnt_hi,
  input  wire logic       rd_cnt_lo,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] cnt_lo,
  output logic      [7:0] cnt_hi,
  output logic      [7:0] cmp_lo,
  output logic      [7:0] cmp_hi,
  output logic      [7:0] latch_hi,
  output logic            match_lo,
  output logic            match_hi
);

  typedef struct packed {
    logic [7:0] cnt_lo;
    logic [7:0] cnt_hi;
    logic [7:0] cmp_lo;
    logic [7:0] cmp_hi;
    logic [7:0] latch_hi;
    logic       match_lo;
    logic       match_hi;
  } ptc_pair_s;

  localparam ptc_pair_s PAIR_RESET = '{
    cnt_lo: CNT_RESET, cnt_hi: CNT_RESET, cmp_lo: CMP_RESET,
    cmp_hi: CMP_RESET, latch_hi: CNT_RESET, match_lo: 1'b0,
    match_hi: 1'b0};

  ptc_pair_s state_reg;
  ptc_pair_s state_next;

  function automatic logic [7:0] cmp_fix(input logic [7:0] d);
    return (d == CMP_ZERO) ? CMP_SUBST : d;
  endfunction

  always_comb begin
    state_next          = state_reg;
    state_next.match_lo = 1'b0;
    state_next.match_hi = 1'b0;
    if (mode16) begin
      if (tick_lo) begin
        if ({state_reg.cnt_hi, state_reg.cnt_lo} ==
            {state_reg.cmp_hi, state_reg.cmp_lo}) begin
          state_next.cnt_lo   = CNT_RESET;
          state_next.cnt_hi   = CNT_RESET;
          state_next.match_hi = 1'b1;
        end else begin
          {state_next.cnt_hi, state_next.cnt_lo} =
            {state_reg.cnt_hi, state_reg.cnt_lo} + 16'h0001;
        end
      end
      if (wr_cnt_lo || wr_cnt_hi) begin
        state_next.cnt_lo = CNT_RESET;
        state_next.cnt_hi = CNT_RESET;
      end
      if (rd_cnt_lo) begin
        state_next.latch_hi = state_reg.cnt_hi;
      end
    end else begin
      if (tick_lo) begin
        if (state_reg.cnt_lo == state_reg.cmp_lo) begin
          state_next.cnt_lo   = CNT_RESET;
          state_next.match_lo = 1'b1;
        end else begin
          state_next.cnt_lo = state_reg.cnt_lo + CNT_ONE;
        end
      end
      if (tick_hi) begin
        if (state_reg.cnt_hi == state_reg.cmp_hi) begin
          state_next.cnt_hi   = CNT_RESET;
          state_next.match_hi = 1'b1;
        end else begin
          state_next.cnt_hi = state_reg.cnt_hi + CNT_ONE;
        end
      end
      if (wr_cnt_lo) begin
        state_next.cnt_lo = CNT_RESET;
      end
      if (wr_cnt_hi) begin
        state_next.cnt_hi = CNT_RESET;
      end
    end
    if (wr_cmp_lo) begin
      state_next.cmp_lo = cmp_fix(wr_data);
    end
    if (wr_cmp_hi) begin
      state_next.cmp_hi = cmp_fix(wr_data);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= PAIR_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign cnt_lo   = state_reg.cnt_lo;
  assign cnt_hi   = state_reg.cnt_hi;
  assign cmp_lo   = state_reg.cmp_lo;
  assign cmp_hi   = state_reg.cmp_hi;
  assign latch_hi = state_reg.latch_hi;
  assign match_lo = state_reg.match_lo;
  assign match_hi = state_reg.match_hi;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_CMP_NONZERO: assert property (cmp_lo != CMP_ZERO && cmp_hi != CMP_ZERO)
    else $error("compare register holds zero");
  AST_CMP_SUBST: assert property (wr_cmp_lo && wr_data == CMP_ZERO |=>
    cmp_lo == CMP_SUBST) else $error("zero compare not replaced by one");
  AST_CNT_CLEAR: assert property (!mode16 && wr_cnt_hi |=>
    cnt_hi == CNT_RESET) else $error("counter write did not clear");
  AST_PAIR_CLEAR: assert property (mode16 && (wr_cnt_lo || wr_cnt_hi) |=>
    cnt_lo == CNT_RESET && cnt_hi == CNT_RESET)
    else $error("paired write did not clear both halves");
  AST_LATCH: assert property (mode16 && rd_cnt_lo |=>
    latch_hi == $past(cnt_hi)) else $error("upper latch not captured");
  AST_MATCH: assert property (!mode16 && tick_lo && !wr_cnt_lo &&
    cnt_lo == cmp_lo |=> match_lo ##0 cnt_lo == CNT_RESET)
    else $error("match did not raise event and restart");
  AST_NO_LO_INT: assert property (mode16 |=> !match_lo)
    else $error("lower event raised in paired mode");
  AST_CARRY: assert property (mode16 && tick_lo && !wr_cnt_lo &&
    !wr_cnt_hi && cnt_lo == CMP_RESET &&
    {cnt_hi, cnt_lo} != {cmp_hi, cmp_lo} |=>
    cnt_hi == $past(cnt_hi) + CNT_ONE && cnt_lo == CNT_RESET)
    else $error("lower overflow did not carry");
  AST_UP: assert property (!mode16 && tick_hi && !wr_cnt_hi &&
    cnt_hi != cmp_hi |=> cnt_hi == $past(cnt_hi) + CNT_ONE)
    else $error("counter did not count up");
  AST_HOLD: assert property (!tick_lo && !wr_cnt_lo && !wr_cnt_hi |=>
    $stable(cnt_lo)) else $error("counter moved without tick");

  COV_MATCH8: cover property (match_lo ##1 tick_lo [*2]);
  COV_MATCH16: cover property (mode16 && match_hi);
  COV_CARRY: cover property (mode16 && tick_lo && cnt_lo == CMP_RESET);
  COV_LATCH: cover property (mode16 && rd_cnt_lo ##1 tick_lo);

endmodule

// File: rtl/ptc_timer_pairs.sv
// six 8-bit timer channels in three joinable pairs behind a byte register port
// assumes ticks come from the clock generator on clk; external clocks are pins
`timescale 1ns/100ps
module ptc_timer_pairs
  import ptc_pkg::*;
(
  input  wire logic [15:0] addr,
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [7:0]  wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  input  wire logic        low_speed_tick,
  input  wire logic        high_speed_time_base_tick,
  input  wire logic        system_clock_is_low,
  input  wire logic [5:0]  ext_count_clock,
  output logic      [7:0]  rd_data,
  output logic             irq
);

  typedef struct packed {
    logic [7:0]  rd_data;
    logic        irq;
    logic [5:0]  run;
    logic [2:0]  mode16;
    logic [11:0] clk_sel;
    logic [5:0]  int_status;
    logic [5:0]  int_mask;
    logic [5:0]  ext_s1;
    logic [5:0]  ext_s2;
    logic [5:0]  ext_s3;
  } ptc_top_s;

  localparam ptc_top_s TOP_RESET = '{
    rd_data: 8'h00, irq: 1'b0, run: CH_RESET, mode16: MODE_RESET,
    clk_sel: SEL_RESET, int_status: CH_RESET, int_mask: CH_RESET,
    ext_s1: CH_RESET, ext_s2: CH_RESET, ext_s3: CH_RESET};

  ptc_top_s   state_reg;
  ptc_top_s   state_next;

  logic [5:0] wr_cmp;
  logic [5:0] wr_cnt;
  logic [5:0] rd_cnt;
  logic [5:0] tick;
  logic [5:0] match;
  logic [5:0] read_ok;
  logic [5:0] ext_edge;
  logic [7:0] cnt_val   [CH_NUM];
  logic [7:0] cmp_val   [CH_NUM];
  logic [7:0] latch_val [PAIR_NUM];
  logic [7:0] rd_value;

  // clock select of a channel; in paired mode the upper half of a pair follows the lower
  function automatic logic [1:0] sel_of(input logic [11:0] sel,
                                        input int          ch);
    return sel[SEL_W*ch +: SEL_W];
  endfunction

  function automatic logic tick_of(input logic [1:0] sel,
                                   input logic       ls,
                                   input logic       htb,
                                   input logic       ext);
    logic t;
    t = 1'b0;
    unique case (sel)
      SEL_LOW: t = ls;
      SEL_HTB: t = htb;
      SEL_OFF: t = 1'b0;
      SEL_EXT: t = ext;
    endcase
    return t;
  endfunction

  // reads on a stopped timer are always good
  function automatic logic read_ok_of(input logic       run,
                                      input logic [1:0] sel,
                                      input logic       sys_low);
    return !run || sel == SEL_LOW || (sel == SEL_HTB && !sys_low);
  endfunction

  // the second and third stages feed the edge detector
  assign ext_edge = state_reg.ext_s2 & ~state_reg.ext_s3;

  for (genvar c = 0; c < CH_NUM; c++) begin : g_ch
    localparam int LEAD = c - (c % 2);
    assign wr_cmp[c] = wr_en && addr == CMP_ADDR[c];
    assign wr_cnt[c] = wr_en && addr == CNT_ADDR[c];
    assign rd_cnt[c] = rd_en && addr == CNT_ADDR[c];
    assign tick[c]   = state_reg.run[c] &&
                       tick_of(sel_of(state_reg.clk_sel, c), low_speed_tick,
                               high_speed_time_base_tick, ext_edge[c]);
    assign read_ok[c] = (c % 2 == 1 && state_reg.mode16[c/2]) ?
      read_ok_of(state_reg.run[LEAD], sel_of(state_reg.clk_sel, LEAD),
                 system_clock_is_low) :
      read_ok_of(state_reg.run[c], sel_of(state_reg.clk_sel, c),
                 system_clock_is_low);
  end

  for (genvar p = 0; p < PAIR_NUM; p++) begin : g_pair
    ptc_pair u_pair (
      .clk       (clk),
      .reset     (reset),
      .tick_lo   (tick[2*p]),
      .tick_hi   (tick[2*p+1]),
      .mode16    (state_reg.mode16[p]),
      .wr_cmp_lo (wr_cmp[2*p]),
      .wr_cmp_hi (wr_cmp[2*p+1]),
      .wr_cnt_lo (wr_cnt[2*p]),
      .wr_cnt_hi (wr_cnt[2*p+1]),
      .rd_cnt_lo (rd_cnt[2*p]),
      .wr_data   (wr_data),
      .cnt_lo    (cnt_val[2*p]),
      .cnt_hi    (cnt_val[2*p+1]),
      .cmp_lo    (cmp_val[2*p]),
      .cmp_hi    (cmp_val[2*p+1]),
      .latch_hi  (latch_val[p]),
      .match_lo  (match[2*p]),
      .match_hi  (match[2*p+1])
    );
  end

  // unmapped addresses read as zero
  always_comb begin
    rd_value = 8'h00;
    for (int c = 0; c < CH_NUM; c++) begin
      if (addr == CMP_ADDR[c]) begin
        rd_value = cmp_val[c];
      end
      if (addr == CNT_ADDR[c]) begin
        if (c % 2 == 1 && state_reg.mode16[c/2]) begin
          rd_value = latch_val[c/2];
        end else begin
          rd_value = cnt_val[c];
        end
      end
    end
    unique case (addr)
      RUN_ADDR:     rd_value = {2'h0, state_reg.run};
      MODE_ADDR:    rd_value = {5'h00, state_reg.mode16};
      SEL_LO_ADDR:  rd_value = state_reg.clk_sel[7:0];
      SEL_HI_ADDR:  rd_value = {4'h0, state_reg.clk_sel[11:8]};
      INT_ST_ADDR:  rd_value = {2'h0, state_reg.int_status};
      INT_MSK_ADDR: rd_value = {2'h0, state_reg.int_mask};
      RD_OK_ADDR:   rd_value = {2'h0, read_ok};
      default:      rd_value = rd_value;
    endcase
  end

  always_comb begin
    state_next         = state_reg;
    state_next.ext_s1  = ext_count_clock;
    state_next.ext_s2  = state_reg.ext_s1;
    state_next.ext_s3  = state_reg.ext_s2;
    state_next.rd_data = rd_en ? rd_value : 8'h00;
    if (wr_en) begin
      unique case (addr)
        RUN_ADDR:     state_next.run     = wr_data[5:0];
        MODE_ADDR:    state_next.mode16  = wr_data[2:0];
        SEL_LO_ADDR:  state_next.clk_sel[7:0]  = wr_data;
        SEL_HI_ADDR:  state_next.clk_sel[11:8] = wr_data[3:0];
        INT_MSK_ADDR: state_next.int_mask = wr_data[5:0];
        INT_ST_ADDR:  state_next.int_status =
                        state_reg.int_status & ~wr_data[5:0];
        default:      state_next.run     = state_reg.run;
      endcase
    end
    // match sets sticky status, set beats clear
    state_next.int_status = state_next.int_status | match;
    state_next.irq = |(state_next.int_status & state_next.int_mask);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg <= TOP_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rd_data = state_reg.rd_data;
  assign irq     = state_reg.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_IRQ_LEVEL: assert property (irq ==
    |(state_reg.int_status & state_reg.int_mask))
    else $error("interrupt output disagrees with status and mask");
  AST_SET_WINS: assert property (match[0] |=> state_reg.int_status[0])
    else $error("match event lost against clear");
  AST_RD_ONCE: assert property (!rd_en |=> rd_data == 8'h00)
    else $error("read data outside read answer cycle");
  AST_STOP_OK: assert property (!state_reg.run[0] &&
    !state_reg.run[1] |-> read_ok[1:0] == 2'h3)
    else $error("stopped channel flagged as unsafe to read");
  AST_EXT_BAD: assert property (state_reg.run[0] &&
    sel_of(state_reg.clk_sel, 0) == SEL_EXT |-> !read_ok[0])
    else $error("external clock running read flagged as safe");

  COV_IRQ: cover property (match[4] && state_reg.int_mask[4] ##1 irq);

endmodule

// File: verification/tb_top.sv
// self-checking bench for the paired timer counter block
// assumes the register port answers reads one cycle after the strobe
`timescale 1ns/100ps
module tb_top;
  import ptc_pkg::*;

  logic        clk;
  logic        reset;
  logic [15:0] addr;
  logic [7:0]  wr_data;
  logic        wr_en;
  logic        rd_en;
  logic        low_speed_tick;
  logic        high_speed_time_base_tick;
  logic        system_clock_is_low;
  logic [5:0]  ext_count_clock;
  logic [7:0]  rd_data;
  logic        irq;
  int          fail_count;
  int          samples_checked;
  logic        ok;

  ptc_timer_pairs ptc_timer_pairs_inst (
    .addr                      (addr),
    .clk                       (clk),
    .reset                     (reset),
    .wr_data                   (wr_data),
    .wr_en                     (wr_en),
    .rd_en                     (rd_en),
    .low_speed_tick            (low_speed_tick),
    .high_speed_time_base_tick (high_speed_time_base_tick),
    .system_clock_is_low       (system_clock_is_low),
    .ext_count_clock           (ext_count_clock),
    .rd_data                   (rd_data),
    .irq                       (irq)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp,
                        input string name);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    check(name, rd_data, exp);
  endtask

  // n back-to-back single-cycle count enables
  task automatic tick(input int n, input bit htb);
    @(posedge clk);
    if (htb) begin
      high_speed_time_base_tick <= 1'b1;
    end else begin
      low_speed_tick <= 1'b1;
    end
    repeat (n) @(posedge clk);
    low_speed_tick            <= 1'b0;
    high_speed_time_base_tick <= 1'b0;
  endtask

  // pin levels last three cycles, above the two-cycle minimum
  task automatic ext_pulse();
    @(posedge clk);
    ext_count_clock[0] <= 1'b1;
    repeat (3) @(posedge clk);
    ext_count_clock[0] <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // generous bound: the sequence needs under 3000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    close_out();
  end

  initial begin
    reset = 1'b1;
    addr = 16'h0000;
    wr_data = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    low_speed_tick = 1'b0;
    high_speed_time_base_tick = 1'b0;
    system_clock_is_low = 1'b0;
    ext_count_clock = 6'h00;
    fail_count = 0;
    samples_checked = 0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;

    for (int c = 0; c < CH_NUM; c++) begin
      rd_chk(CMP_ADDR[c], CMP_RESET, "compare reset");
      rd_chk(CNT_ADDR[c], CNT_RESET, "count reset");
      wr(CMP_ADDR[c], CMP_ZERO);
      rd_chk(CMP_ADDR[c], CMP_SUBST, "compare zero");
      wr(CMP_ADDR[c], CMP_RESET);
    end
    rd_chk(INT_ST_ADDR, 8'h00, "status reset");
    check("irq reset", {7'h00, irq}, 8'h00);
    $display("test reset_and_compare done");

    wr(CMP_ADDR[0], 8'h03);
    rd_chk(CMP_ADDR[0], 8'h03, "compare write");
    wr(RUN_ADDR, 8'h01);
    tick(3, 1'b0);
    rd_chk(CNT_ADDR[0], 8'h03, "count up");
    rd_chk(CNT_ADDR[0], 8'h03, "count up repeat");
    rd_chk(INT_ST_ADDR, 8'h00, "no early match");
    tick(1, 1'b0);
    rd_chk(CNT_ADDR[0], 8'h00, "restart after match");
    rd_chk(INT_ST_ADDR, 8'h01, "match status");
    check("irq masked", {7'h00, irq}, 8'h00);
    wr(INT_MSK_ADDR, 8'h01);
    repeat (2) @(posedge clk);
    #1;
    check("irq unmasked", {7'h00, irq}, 8'h01);
    wr(INT_ST_ADDR, 8'h01);
    repeat (2) @(posedge clk);
    #1;
    check("irq cleared", {7'h00, irq}, 8'h00);
    rd_chk(INT_ST_ADDR, 8'h00, "status cleared");
    @(posedge clk);
    #1;
    check("read data idle", rd_data, 8'h00);
    tick(2, 1'b0);
    wr(CNT_ADDR[0], 8'ha5);
    rd_chk(CNT_ADDR[0], 8'h00, "count write clears");
    $display("test eight_bit_count done");

    wr(MODE_ADDR, 8'h02);
    wr(RUN_ADDR, 8'h04);
    tick(260, 1'b0);
    rd_chk(CNT_ADDR[2], 8'h04, "pair lower");
    rd_chk(CNT_ADDR[3], 8'h01, "pair upper latch");
    tick(1, 1'b0);
    rd_chk(CNT_ADDR[3], 8'h01, "stale latch");
    rd_chk(INT_ST_ADDR, 8'h00, "no lower event");
    wr(CNT_ADDR[3], 8'h77);
    rd_chk(CNT_ADDR[2], 8'h00, "joint clear lower");
    rd_chk(CNT_ADDR[3], 8'h00, "joint clear upper");
    wr(RUN_ADDR, 8'h00);
    wr(CMP_ADDR[2], 8'h02);
    wr(CMP_ADDR[3], 8'h01);
    wr(RUN_ADDR, 8'h04);
    tick(258, 1'b0);
    rd_chk(CNT_ADDR[2], 8'h02, "pair at compare");
    rd_chk(CNT_ADDR[3], 8'h01, "pair upper at compare");
    rd_chk(INT_ST_ADDR, 8'h00, "pair before match");
    tick(1, 1'b0);
    rd_chk(INT_ST_ADDR, 8'h08, "upper event only");
    rd_chk(CNT_ADDR[2], 8'h00, "pair restart");
    rd_chk(CNT_ADDR[3], 8'h00, "pair upper restart");
    wr(INT_ST_ADDR, 8'h08);
    $display("test sixteen_bit done");

    wr(RUN_ADDR, 8'h01);
    for (int s = 0; s < 2; s++) begin
      for (int c = 0; c < 4; c++) begin
        system_clock_is_low <= s[0];
        wr(SEL_LO_ADDR, {6'h00, c[1:0]});
        ok = (c[1:0] == SEL_LOW) || (c[1:0] == SEL_HTB && s == 0);
        rd_chk(RD_OK_ADDR, {7'h1f, ok}, "read valid flag");
      end
    end
    system_clock_is_low <= 1'b0;
    wr(CNT_ADDR[0], 8'h00);
    ext_pulse();
    ext_pulse();
    repeat (5) @(posedge clk);
    rd_chk(CNT_ADDR[0], 8'h02, "external count");
    wr(SEL_LO_ADDR, {6'h00, SEL_HTB});
    wr(CNT_ADDR[0], 8'h00);
    tick(3, 1'b1);
    rd_chk(CNT_ADDR[0], 8'h03, "time base count");
    wr(16'hf047, 8'h5a);
    rd_chk(16'hf047, 8'h00, "unmapped read");
    $display("test clock_select done");
    close_out();
  end
endmodule
